// ### logic/tcp_params.svh
/*
  Constants for the two-channel capture/compare/PWM timer: register
  offsets, field positions, reset values and codes.
  Assumes inclusion by bare name from each design file that needs them.
*/
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// register offsets, one byte each
`define TCP_OFF_TCS     4'h0
`define TCP_OFF_CNT_HI  4'h1
`define TCP_OFF_CNT_LO  4'h2
`define TCP_OFF_WRAP_HI 4'h3
`define TCP_OFF_WRAP_LO 4'h4
`define TCP_OFF_CH0_CS  4'h5
`define TCP_OFF_CH0_HI  4'h6
`define TCP_OFF_CH0_LO  4'h7
`define TCP_OFF_CH1_CS  4'h8
`define TCP_OFF_CH1_HI  4'h9
`define TCP_OFF_CH1_LO  4'ha

// timer control/status fields
`define TCP_TCS_FLAG    7
`define TCP_TCS_IE      6
`define TCP_TCS_HALT    5
`define TCP_TCS_RESET   4
`define TCP_TCS_SEL_HI  2
`define TCP_TCS_SEL_LO  0

// channel control/status fields
`define TCP_CCS_FLAG    7
`define TCP_CCS_IE      6
`define TCP_CCS_MODE_HI 5
`define TCP_CCS_MODE_LO 4
`define TCP_CCS_ELS_HI  3
`define TCP_CCS_ELS_LO  2
`define TCP_CCS_TOV     1
`define TCP_CCS_MAX     0

// reset values
`define TCP_WRAP_RST    16'hffff
`define TCP_VAL_RST     16'h0000
`define TCP_SEL_RST     3'h0

// mode and edge/level codes
`define TCP_MODE_CAPT   2'h0
`define TCP_MODE_UNBUF  2'h1
`define TCP_ELS_OFF     2'h0
`define TCP_ELS_RISE    2'h1
`define TCP_ELS_FALL    2'h2
`define TCP_ELS_BOTH    2'h3
`define TCP_ELS_TOGGLE  2'h1
`define TCP_ELS_CLEAR   2'h2
`define TCP_ELS_SET     2'h3
`define TCP_SEL_NONE    3'h7

`endif

// ### logic/tcp_pkg.sv
/*
  Types shared by the timer design files.
  Assumes tcp_params.svh supplies the numeric constants.
*/
`default_nettype none

package tcp_pkg;

  // per-channel control fields as software writes them
  typedef struct packed {
    logic irq_en;
    logic [1:0] mode;
    logic [1:0] edge_level;
    logic tov;
    logic full_duty;
  } tcp_chan_ctrl_t;

  // timer-wide control fields
  typedef struct packed {
    logic irq_en;
    logic halt;
    logic [2:0] div_sel;
  } tcp_tmr_ctrl_t;

endpackage : tcp_pkg

`default_nettype wire

// ### logic/tcp_prescaler.sv
/*
  Prescaler: turns the bus clock into one-cycle timer ticks at
  bus/1 .. bus/64. Assumes i_clear and i_run are synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tcp_params.svh"

module tcp_prescaler (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_clear,
  input wire logic i_run,
  input wire logic [2:0] i_sel,
  // tick out
  output logic o_tick
);

  logic [5:0] div_cnt_r;
  logic [5:0] mask;

  // low bits that must all be ones for a tick
  always_comb begin
    case (i_sel)
      3'h0: mask = 6'h00;
      3'h1: mask = 6'h01;
      3'h2: mask = 6'h03;
      3'h3: mask = 6'h07;
      3'h4: mask = 6'h0f;
      3'h5: mask = 6'h1f;
      3'h6: mask = 6'h3f;
      default: mask = 6'h00;
    endcase
  end

  // free divider, frozen while halted
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_r <= 6'h00;
    end else if (i_clear) begin
      div_cnt_r <= 6'h00;
    end else if (i_run) begin
      div_cnt_r <= div_cnt_r + 6'h01;
    end
  end

  // code 111 gives no tick at all
  assign o_tick = i_run && (i_sel != `TCP_SEL_NONE)
                  && ((div_cnt_r & mask) == mask);

endmodule : tcp_prescaler

`default_nettype wire

// ### logic/tcp_timer.sv
/*
  Two-channel timer: 16-bit wrapping counter, capture, compare, PWM,
  linked buffered compare on channel 0. Byte registers on a plain port.
  Assumes pins already synchronous to i_clk and a master that never
  issues read and write strobes together.
*/
// The implementer's own choices: the strobed register port and the placing of the registers.
// Function
// - seven counter rates from bus clock
// - codes 000-110 divide 1..64; 111 invalid
// - wrap at limit sets flag, restarts
// - active capture edge copies counter
// - software edge polarity, capture interrupt
// - events set channel flag, gated interrupt
// - compare match sets, clears or toggles pin
// - unbuffered value write takes effect immediately
// - pair-link bit joins channels onto pin 0
// - linked: channel 0 first, newest at wrap
// - linked: channel 0 controls, pin 1 freed
// - toggle on wrap gives PWM period
// - pulse width from wrap to match
// - period one tick longer than limit
// - linked PWM switch at next period
// - mode 01 unbuffered, 10 buffered
// - edge/level 10 clears, 11 sets
// - no wrap toggle gives 0% duty
// - full duty plus wrap toggle: 100%
`timescale 1ns/1ns
`default_nettype none
`include "tcp_params.svh"

module tcp_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // channel pins
  input wire logic [1:0] i_chan_pin,
  output logic [1:0] o_chan_pin,
  output logic [1:0] o_chan_pin_oe,
  // interrupt requests
  output logic o_wrap_irq,
  output logic [1:0] o_chan_irq
);

  tcp_pkg::tcp_tmr_ctrl_t tmr_ctrl_r;
  tcp_pkg::tcp_chan_ctrl_t chan_ctrl_r [2];
  logic [15:0] cnt_r;
  logic [15:0] wrap_r;
  logic [15:0] val_r [2];
  logic [1:0] chan_flag_r;
  logic [1:0] chan_arm_r;
  logic [1:0] pin_r;
  logic [1:0] pin_oe_r;
  logic [1:0] pin_prev_r;
  logic [1:0] chan_irq_r;
  logic wrap_flag_r;
  logic wrap_arm_r;
  logic wrap_inhibit_r;
  logic wrap_irq_r;
  logic active_sel_r;
  logic last_written_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic tick;
  logic ctr_reset;
  logic wrap_hit;
  logic linked;
  logic [1:0] cap_evt;
  logic [1:0] cmp_evt;
  logic [1:0] chan_evt;
  logic [1:0] lo_write;

  assign ctr_reset = i_wr && (i_addr == `TCP_OFF_TCS) && i_wdata[`TCP_TCS_RESET];
  assign wrap_hit = tick && (cnt_r == wrap_r);
  assign linked = chan_ctrl_r[0].mode[1];

  tcp_prescaler u_presc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(ctr_reset),
    .i_run(!tmr_ctrl_r.halt),
    .i_sel(tmr_ctrl_r.div_sel),
    .o_tick(tick)
  );

  // counter; a reset request wins over a pending tick
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= 16'h0000;
    end else if (ctr_reset) begin
      cnt_r <= 16'h0000;
    end else if (wrap_hit) begin
      cnt_r <= 16'h0000;
    end else if (tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // timer control; halt set at reset so the counter stays still until released
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tmr_ctrl_r.irq_en <= 1'b0;
      tmr_ctrl_r.halt <= 1'b1;
      tmr_ctrl_r.div_sel <= `TCP_SEL_RST;
    end else if (i_wr && (i_addr == `TCP_OFF_TCS)) begin
      tmr_ctrl_r.irq_en <= i_wdata[`TCP_TCS_IE];
      tmr_ctrl_r.halt <= i_wdata[`TCP_TCS_HALT];
      tmr_ctrl_r.div_sel <= i_wdata[`TCP_TCS_SEL_HI:`TCP_TCS_SEL_LO];
    end
  end

  // wrap limit; high-byte write holds off the flag until low byte lands
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wrap_r <= `TCP_WRAP_RST;
      wrap_inhibit_r <= 1'b0;
    end else if (i_wr && (i_addr == `TCP_OFF_WRAP_HI)) begin
      wrap_r[15:8] <= i_wdata;
      wrap_inhibit_r <= 1'b1;
    end else if (i_wr && (i_addr == `TCP_OFF_WRAP_LO)) begin
      wrap_r[7:0] <= i_wdata;
      wrap_inhibit_r <= 1'b0;
    end
  end

  // wrap flag: read-while-set arms, write 0 clears; a new wrap wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wrap_flag_r <= 1'b0;
      wrap_arm_r <= 1'b0;
    end else if (wrap_hit && !wrap_inhibit_r) begin
      wrap_flag_r <= 1'b1;
      wrap_arm_r <= 1'b0;
    end else if (i_rd && (i_addr == `TCP_OFF_TCS) && wrap_flag_r) begin
      wrap_arm_r <= 1'b1;
    end else if (i_wr && (i_addr == `TCP_OFF_TCS) && wrap_arm_r
                 && !i_wdata[`TCP_TCS_FLAG]) begin
      wrap_flag_r <= 1'b0;
      wrap_arm_r <= 1'b0;
    end
  end

  // buffered pair: channel 0 first, newest-written takes over at wrap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      active_sel_r <= 1'b0;
      last_written_r <= 1'b0;
    end else if (!linked) begin
      active_sel_r <= 1'b0;
      last_written_r <= 1'b0;
    end else begin
      if (lo_write[1]) begin
        last_written_r <= 1'b1;
      end else if (lo_write[0]) begin
        last_written_r <= 1'b0;
      end
      if (wrap_hit) begin
        active_sel_r <= lo_write[1] ? 1'b1 : (lo_write[0] ? 1'b0 : last_written_r);
      end
    end
  end

  // per-channel capture, compare and pin logic
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      localparam logic [3:0] CS_OFF = (g == 0) ? `TCP_OFF_CH0_CS : `TCP_OFF_CH1_CS;
      localparam logic [3:0] HI_OFF = (g == 0) ? `TCP_OFF_CH0_HI : `TCP_OFF_CH1_HI;
      localparam logic [3:0] LO_OFF = (g == 0) ? `TCP_OFF_CH0_LO : `TCP_OFF_CH1_LO;
      logic off_by_link;
      logic is_capt;
      logic is_cmp;
      logic rise;
      logic fall;
      logic [15:0] cmp_val;
      tcp_pkg::tcp_chan_ctrl_t c;

      assign c = chan_ctrl_r[g];
      assign off_by_link = (g == 1) && linked;
      assign is_capt = !off_by_link && (c.mode == `TCP_MODE_CAPT)
                       && (c.edge_level != `TCP_ELS_OFF);
      assign is_cmp = !off_by_link && (c.mode != `TCP_MODE_CAPT)
                      && (c.edge_level != `TCP_ELS_OFF);
      assign rise = i_chan_pin[g] && !pin_prev_r[g];
      assign fall = !i_chan_pin[g] && pin_prev_r[g];
      // linked channel 0 compares against whichever pair is active
      assign cmp_val = (g == 0 && linked) ? val_r[active_sel_r] : val_r[g];
      assign cap_evt[g] = is_capt && (((c.edge_level == `TCP_ELS_RISE) && rise)
                          || ((c.edge_level == `TCP_ELS_FALL) && fall)
                          || ((c.edge_level == `TCP_ELS_BOTH) && (rise || fall)));
      assign cmp_evt[g] = is_cmp && tick && (cnt_r == cmp_val);
      assign chan_evt[g] = cap_evt[g] || cmp_evt[g];
      assign lo_write[g] = i_wr && (i_addr == LO_OFF);

      // previous pin level for edge detection
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          pin_prev_r[g] <= 1'b0;
        end else begin
          pin_prev_r[g] <= i_chan_pin[g];
        end
      end

      // channel control; channel 1 has no buffered mode bit
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          chan_ctrl_r[g] <= '0;
        end else if (i_wr && (i_addr == CS_OFF)) begin
          chan_ctrl_r[g].irq_en <= i_wdata[`TCP_CCS_IE];
          chan_ctrl_r[g].mode <= {(g == 0) && i_wdata[`TCP_CCS_MODE_HI],
                                  i_wdata[`TCP_CCS_MODE_LO]};
          chan_ctrl_r[g].edge_level <= i_wdata[`TCP_CCS_ELS_HI:`TCP_CCS_ELS_LO];
          chan_ctrl_r[g].tov <= i_wdata[`TCP_CCS_TOV];
          chan_ctrl_r[g].full_duty <= i_wdata[`TCP_CCS_MAX];
        end
      end

      // value pair; a capture beats a same-cycle software write
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          val_r[g] <= `TCP_VAL_RST;
        end else if (cap_evt[g]) begin
          val_r[g] <= cnt_r;
        end else if (i_wr && (i_addr == HI_OFF)) begin
          val_r[g][15:8] <= i_wdata;
        end else if (lo_write[g]) begin
          val_r[g][7:0] <= i_wdata;
        end
      end

      // channel flag, same two-step clear as the wrap flag; set wins
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          chan_flag_r[g] <= 1'b0;
          chan_arm_r[g] <= 1'b0;
        end else if (chan_evt[g]) begin
          chan_flag_r[g] <= 1'b1;
          chan_arm_r[g] <= 1'b0;
        end else if (i_rd && (i_addr == CS_OFF) && chan_flag_r[g]) begin
          chan_arm_r[g] <= 1'b1;
        end else if (i_wr && (i_addr == CS_OFF) && chan_arm_r[g]
                     && !i_wdata[`TCP_CCS_FLAG]) begin
          chan_flag_r[g] <= 1'b0;
          chan_arm_r[g] <= 1'b0;
        end
      end

      // pin drive; compare action lands after the wrap toggle
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          pin_r[g] <= 1'b0;
          pin_oe_r[g] <= 1'b0;
        end else begin
          pin_oe_r[g] <= is_cmp;
          if (is_cmp && wrap_hit && c.tov) begin
            pin_r[g] <= c.full_duty ? 1'b1 : !pin_r[g];
          end
          // full duty with wrap toggle suppresses every compare action
          if (cmp_evt[g] && !(c.tov && c.full_duty)) begin
            case (c.edge_level)
              `TCP_ELS_TOGGLE: pin_r[g] <= !pin_r[g];
              `TCP_ELS_CLEAR: pin_r[g] <= 1'b0;
              `TCP_ELS_SET: pin_r[g] <= 1'b1;
              default: pin_r[g] <= pin_r[g];
            endcase
          end
        end
      end

      // gated request, registered for a clean output
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          chan_irq_r[g] <= 1'b0;
        end else begin
          chan_irq_r[g] <= chan_flag_r[g] && c.irq_en && !off_by_link;
        end
      end
    end
  endgenerate

  // wrap request only while enabled
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wrap_irq_r <= 1'b0;
    end else begin
      wrap_irq_r <= wrap_flag_r && tmr_ctrl_r.irq_en;
    end
  end

  // read mux; the reset bit and unmapped offsets read zero
  always_comb begin
    rdata_nxt = 8'h00;
    case (i_addr)
      `TCP_OFF_TCS: rdata_nxt = {wrap_flag_r, tmr_ctrl_r.irq_en, tmr_ctrl_r.halt,
                                 2'h0, tmr_ctrl_r.div_sel};
      `TCP_OFF_CNT_HI: rdata_nxt = cnt_r[15:8];
      `TCP_OFF_CNT_LO: rdata_nxt = cnt_r[7:0];
      `TCP_OFF_WRAP_HI: rdata_nxt = wrap_r[15:8];
      `TCP_OFF_WRAP_LO: rdata_nxt = wrap_r[7:0];
      `TCP_OFF_CH0_CS: rdata_nxt = {chan_flag_r[0], chan_ctrl_r[0]};
      `TCP_OFF_CH0_HI: rdata_nxt = val_r[0][15:8];
      `TCP_OFF_CH0_LO: rdata_nxt = val_r[0][7:0];
      `TCP_OFF_CH1_CS: rdata_nxt = {chan_flag_r[1], chan_ctrl_r[1]};
      `TCP_OFF_CH1_HI: rdata_nxt = val_r[1][15:8];
      `TCP_OFF_CH1_LO: rdata_nxt = val_r[1][7:0];
      default: rdata_nxt = 8'h00;
    endcase
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= i_rd ? rdata_nxt : 8'h00;
    end
  end

  assign o_rdata = rdata_r;
  assign o_chan_pin = pin_r;
  assign o_chan_pin_oe = pin_oe_r;
  assign o_wrap_irq = wrap_irq_r;
  assign o_chan_irq = chan_irq_r;

endmodule : tcp_timer

`default_nettype wire

// ### tb/tcp_timer_sva.sv
/*
  Checker for the timer top ports: config, gating, linked and halt relations.
  Assumes binding onto tcp_timer and a master that never overlaps strobes.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tcp_params.svh"

module tcp_timer_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // watched ports
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] i_chan_pin,
  input wire logic [1:0] o_chan_pin,
  input wire logic [1:0] o_chan_pin_oe,
  input wire logic o_wrap_irq,
  input wire logic [1:0] o_chan_irq
);
  logic link_r;
  logic halt_r;

  // shadow of link and halt bits, decoded from register writes
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      link_r <= 1'b0;
      halt_r <= 1'b1;
    end else if (i_wr && i_addr == `TCP_OFF_CH0_CS) begin
      link_r <= i_wdata[5];
    end else if (i_wr && i_addr == `TCP_OFF_TCS) begin
      halt_r <= i_wdata[5];
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // drive enable follows the control register two edges later
  cfg_oe0_a: assert property (i_wr && i_addr == `TCP_OFF_CH0_CS ##1
    !(i_wr && i_addr == `TCP_OFF_CH0_CS) |-> ##1
    o_chan_pin_oe[0] == ($past(i_wdata[5:4], 2) != 2'h0 && $past(i_wdata[3:2], 2) != 2'h0))
    else $error("chan0 drive enable does not follow its mode");
  cfg_oe1_a: assert property (i_wr && i_addr == `TCP_OFF_CH1_CS && !link_r ##1
    !(i_wr && i_addr == `TCP_OFF_CH1_CS) |-> ##1
    o_chan_pin_oe[1] == ($past(i_wdata[4], 2) && $past(i_wdata[3:2], 2) != 2'h0))
    else $error("chan1 drive enable does not follow its mode");
  chan_irq_gate_a: assert property (i_wr && i_addr == `TCP_OFF_CH0_CS && !i_wdata[6]
    |-> ##2 !o_chan_irq[0]) else $error("chan0 request while disabled");
  wrap_irq_gate_a: assert property (i_wr && i_addr == `TCP_OFF_TCS && !i_wdata[6]
    |-> ##2 !o_wrap_irq) else $error("wrap request while disabled");
  link_free_a: assert property (link_r && $past(link_r) && $past(link_r, 2)
    |-> o_chan_pin_oe[1] == 1'b0 && o_chan_irq[1] == 1'b0)
    else $error("chan1 still active while linked");
  ch1_read_a: assert property ($past(i_rd && i_addr == `TCP_OFF_CH1_CS)
    |-> !o_rdata[5]) else $error("chan1 link bit reads set");
  ctrl_read_a: assert property ($past(i_rd && i_addr == `TCP_OFF_TCS)
    |-> o_rdata[4:3] == 2'h0) else $error("timer ctrl reserved bits read set");
  halt_pin_a: assert property (halt_r && $past(halt_r) && $past(halt_r, 2)
    && !$past(i_wr) && !$past(i_wr, 2) |-> $stable(o_chan_pin))
    else $error("pin moved while counter halted");

  // main scenarios reached
  cover property (o_chan_irq[1] && !link_r);
  cover property (o_wrap_irq);
  cover property (link_r && o_chan_pin_oe[0]);
endmodule : tcp_timer_sva

`default_nettype wire

// ### tb/tcp_pin_model.sv
/*
  Outside world on the two channel pins: a driven source per pin.
  Assumes the bench sets the source level; the timer drive wins when enabled.
*/
`timescale 1ns/1ns
`default_nettype none

module tcp_pin_model (
  // outside source
  input wire logic [1:0] i_ext_level,
  // timer side
  input wire logic [1:0] i_drive,
  input wire logic [1:0] i_drive_oe,
  // resolved wire
  output logic [1:0] o_wire
);
  // resolve each pin; no keeper, source always driven
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      o_wire[g] = i_drive_oe[g] ? i_drive[g] : i_ext_level[g];
    end
  end
endmodule : tcp_pin_model

`default_nettype wire

// ### tb/tb_top.sv
/*
  Self-checking bench for the timer: register tasks and scenarios.
  Assumes the pin model and checker are compiled before this file.
*/
`timescale 1ns/1ns
`default_nettype none
`include "tcp_params.svh"

module tb_top;
  logic clk, rst, wr, rd, wrap_irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [1:0] ext, pin_in, pin_out, oe, ch_irq;
  int n_fail, comparisons, hi, rises;

  tcp_timer i_dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_chan_pin(pin_in), .o_chan_pin(pin_out),
    .o_chan_pin_oe(oe), .o_wrap_irq(wrap_irq), .o_chan_irq(ch_irq));
  tcp_pin_model i_pins (.i_ext_level(ext), .i_drive(pin_out), .i_drive_oe(oe), .o_wire(pin_in));

  // free-running bus clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // a 4-period window of a periodic pin gives phase-free counts
  task automatic measure(input int win);
    logic prev;
    hi = 0;
    rises = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    prev = pin_out[0];
    repeat (win) begin
      @(negedge clk);
      hi += (pin_out[0] === 1'b1);
      rises += (pin_out[0] === 1'b1 && prev === 1'b0);
      prev = pin_out[0];
    end
  endtask : measure

  task automatic setup(input logic [15:0] w, input logic [15:0] v, input logic [7:0] c);
    wr_reg(`TCP_OFF_TCS, 8'h30);
    wr_reg(`TCP_OFF_WRAP_HI, w[15:8]);
    wr_reg(`TCP_OFF_WRAP_LO, w[7:0]);
    wr_reg(`TCP_OFF_CH0_HI, v[15:8]);
    wr_reg(`TCP_OFF_CH0_LO, v[7:0]);
    wr_reg(`TCP_OFF_CH0_CS, c);
    wr_reg(`TCP_OFF_TCS, 8'h40);
  endtask : setup

  task automatic t_reset();
    wr_reg(4'hb, 8'hff);
    rd_reg(`TCP_OFF_TCS, d);
    chk(d, 8'h20);
    rd_reg(`TCP_OFF_WRAP_LO, d);
    chk(d, 8'hff);
    rd_reg(4'hb, d);
    chk(d, 8'h00);
  endtask : t_reset

  task automatic t_rates();
    for (int s = 0; s < 8; s++) begin
      wr_reg(`TCP_OFF_TCS, 8'h30);
      wr_reg(`TCP_OFF_TCS, 8'h10 | 8'(s));
      repeat (16 << s) @(posedge clk);
      wr_reg(`TCP_OFF_TCS, 8'h20);
      rd_reg(`TCP_OFF_CNT_LO, d);
      chk(s == 7 ? d === 8'h00 : d >= 8'd15 && d <= 8'd18, 1'b1);
    end
  endtask : t_rates

  task automatic t_pwm();
    int wl[5] = '{7, 7, 7, 7, 255};
    int vl[5] = '{2, 2, 2, 2, 128};
    logic [7:0] cc[5] = '{8'h5a, 8'h1e, 8'h18, 8'h1b, 8'h1a};
    int eh[5] = '{12, 20, 0, 32, 516};
    int er[5] = '{4, 4, 0, 0, 4};
    for (int i = 0; i < 5; i++) begin
      setup(16'(wl[i]), 16'(vl[i]), cc[i]);
      measure(4 * (wl[i] + 1));
      chk(16'(hi), 16'(eh[i]));
      chk(16'(rises), 16'(er[i]));
      chk(oe[0], 1'b1);
      chk(wrap_irq, 1'b1);
      chk(ch_irq[0], cc[i][6]);
    end
  endtask : t_pwm

  // unbuffered value changes made from inside the compare and the wrap requests
  task automatic t_resync();
    setup(16'h7, 16'h2, 8'h5a);
    rd_reg(`TCP_OFF_CH0_CS, d);
    wr_reg(`TCP_OFF_CH0_CS, 8'h5a);
    repeat (2) @(posedge clk);
    wait (ch_irq[0] === 1'b1);
    wr_reg(`TCP_OFF_CH0_LO, 8'h01);
    measure(32);
    chk(16'(hi), 16'd8);
    rd_reg(`TCP_OFF_TCS, d);
    wr_reg(`TCP_OFF_TCS, 8'h40);
    repeat (2) @(posedge clk);
    wait (wrap_irq === 1'b1);
    wr_reg(`TCP_OFF_CH0_LO, 8'h04);
    measure(32);
    chk(16'(hi), 16'd20);
  endtask : t_resync

  // one rising then one falling edge per capture polarity
  task automatic t_capture();
    logic [7:0] cnt;
    wr_reg(`TCP_OFF_TCS, 8'h10);
    repeat (9) @(posedge clk);
    wr_reg(`TCP_OFF_TCS, 8'h20);
    rd_reg(`TCP_OFF_CNT_LO, cnt);
    for (int e = 1; e < 4; e++) begin
      wr_reg(`TCP_OFF_CH1_CS, 8'h40 | 8'(e << 2));
      for (int f = 0; f < 2; f++) begin
        @(posedge clk);
        ext[1] <= !f[0];
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk(ch_irq[1], e[f]);
        rd_reg(`TCP_OFF_CH1_CS, d);
        wr_reg(`TCP_OFF_CH1_CS, 8'h40 | 8'(e << 2));
      end
    end
    rd_reg(`TCP_OFF_CH1_LO, d);
    chk(d, cnt);
    // halted count equals the captured value, so the first tick matches
    wr_reg(`TCP_OFF_CH1_CS, 8'h1c);
    wr_reg(`TCP_OFF_TCS, 8'h00);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(pin_out[1], 1'b1);
    chk(oe[1], 1'b1);
  endtask : t_capture

  task automatic t_link();
    setup(16'h7, 16'h2, 8'h2a);
    measure(32);
    chk(16'(hi), 16'd12);
    wr_reg(`TCP_OFF_CH1_HI, 8'h00);
    wr_reg(`TCP_OFF_CH1_LO, 8'h05);
    measure(32);
    chk(16'(hi), 16'd24);
    chk({oe[1], ch_irq[1]}, 2'b00);
    wr_reg(`TCP_OFF_CH0_LO, 8'h01);
    measure(32);
    chk(16'(hi), 16'd8);
  endtask : t_link

  // main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    ext = 2'h0;
    n_fail = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_rates();
    t_pwm();
    t_resync();
    t_capture();
    t_link();
    results();
  end

  // watchdog, about ten times the expected run
  initial begin
    #1_000_000;
    n_fail++;
    results();
  end
endmodule : tb_top

bind tcp_timer tcp_timer_sva i_sva (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_chan_pin(i_chan_pin),
  .o_chan_pin(o_chan_pin), .o_chan_pin_oe(o_chan_pin_oe), .o_wrap_irq(o_wrap_irq),
  .o_chan_irq(o_chan_irq));

`default_nettype wire
